/* logic/mei_irq.sv */
// Metering event interrupt enable mask with sticky status and irq.
// Assumes datapath levels synchronous to ref_clk_i, Avalon-MM slave.
//
// Function
// - Mask bit 0 enables an interrupt when bit 30 of any total active energy accumulator toggles.
// - Mask bit 1 does the same for the fundamental active energy accumulators.
// - Mask bit 2 does the same for the total reactive energy accumulators.
// - Mask bit 3 does the same for the fundamental reactive energy accumulators.
// - Mask bit 4 does the same for the apparent energy accumulators.
// - Mask bit 5 enables an interrupt at the end of a line-cycle accumulation run.
// - Mask bits 6..8 enable sign change interrupts on phase active power, source by mode bit 0.
// - Mask bits 10..12 enable sign change interrupts on phase reactive power, source by mode bit 1.
// - Mask bits 9, 13, 18 enable sign change interrupts on the three output power sums.
// - Mask bits 14..16 enable interrupts on falling edges of the three frequency outputs.
// - Frequency output interrupts fire even when that output pin is disabled.
// - Each frequency output's sum sign takes its power quantity from a 3-bit select field; the pin follows freq_out_pulse_i.
// - Mask bit 17 enables an interrupt when each 8 kHz DSP pass finishes.
// - Mask bits 31..19 are reserved, reset to zero and do nothing.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
module mei_irq (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [2:0] tot_act_hi_i,
  input wire logic [2:0] fund_act_hi_i,
  input wire logic [2:0] tot_rea_hi_i,
  input wire logic [2:0] fund_rea_hi_i,
  input wire logic [2:0] app_hi_i,
  input wire logic line_accum_mode_i,
  input wire logic line_accum_end_i,
  input wire logic [2:0] tot_act_neg_i,
  input wire logic [2:0] fund_act_neg_i,
  input wire logic [2:0] tot_rea_neg_i,
  input wire logic [2:0] fund_rea_neg_i,
  input wire logic [7:0] power_neg_i,
  input wire logic [2:0] freq_out_pulse_i,
  output logic [2:0] freq_out_o,
  output logic irq_n_o
);
  logic [18:0] event_irq_enable_0;
  logic [18:0] status;
  logic [1:0] measurement_mode_reg;
  logic [11:0] freq_out_mode_reg;
  logic [15:0] half_cycle_count_reg;
  logic [31:0] dsp_cnt;
  logic [31:0] next_dsp_cnt;
  logic dsp_done;
  logic [2:0] cf_run;
  logic [2:0] cf_sign;
  logic [14:0] edge_lvl;
  logic [14:0] edge_pulse;
  logic [18:0] evt;
  logic [18:0] next_status;
  logic pending;
  logic acc_done;
  logic [31:0] rd_mux;
  logic [31:0] be_mask;

  // Bus decode; one wait state so every access answers on the second edge
  wire logic req = (avs_read | avs_write) & avs_waitrequest & ~acc_done;
  wire logic sel_en = (avs_address == mei_pkg::OFS_ENABLE_0[13:0]);
  wire logic sel_st = (avs_address == mei_pkg::OFS_STATUS_0[13:0]);
  wire logic sel_mm = (avs_address == mei_pkg::OFS_MEAS_MODE[13:0]);
  wire logic sel_cf = (avs_address == mei_pkg::OFS_FREQ_MODE[13:0]);
  wire logic sel_lc = (avs_address == mei_pkg::OFS_HALF_CYC[13:0]);
  wire logic hit = sel_en | sel_st | sel_mm | sel_cf | sel_lc;
  wire logic wr_go = avs_write & acc_done;
  wire logic [31:0] wdat = avs_writedata & be_mask;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_be
      assign be_mask[8*b +: 8] = {8{avs_byteenable[b]}};
    end
  endgenerate

  // Sign sources chosen by measurement mode
  wire logic [2:0] act_neg = measurement_mode_reg[mei_pkg::MM_ACT_SEL] ?
                             fund_act_neg_i : tot_act_neg_i;
  wire logic [2:0] rea_neg = measurement_mode_reg[mei_pkg::MM_REA_SEL] ?
                             fund_rea_neg_i : tot_rea_neg_i;

  // Per-output power select and sum sign; each pulse pin follows its own freq_out_pulse_i line
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_cf
      wire logic [2:0] psel = freq_out_mode_reg[mei_pkg::CFM_SEL1_LO + 3*c +: 3];
      assign cf_sign[c] = power_neg_i[psel];
      assign cf_run[c] = freq_out_pulse_i[c];
    end
  endgenerate

  // Levels whose changes become events: phase signs, sum signs, pulse lines (falls only)
  assign edge_lvl = {cf_run, cf_sign, rea_neg, act_neg, 3'h0};

  mei_edge u_edge (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .lvl_i(edge_lvl),
    .fall_only_i({3'h7, 12'h000}),
    .pulse_o(edge_pulse)
  );

  // Accumulator bit-30 toggle per group: any of the three phases
  logic [14:0] acc_prev;
  wire logic [14:0] acc_now = {app_hi_i, fund_rea_hi_i, tot_rea_hi_i, fund_act_hi_i, tot_act_hi_i};
  wire logic [14:0] acc_tgl = acc_now ^ acc_prev;

  always_comb begin
    evt = 19'h00000;
    evt[mei_pkg::BIT_TOT_ACT] = |acc_tgl[2:0];
    evt[mei_pkg::BIT_FUND_ACT] = |acc_tgl[5:3];
    evt[mei_pkg::BIT_TOT_REA] = |acc_tgl[8:6];
    evt[mei_pkg::BIT_FUND_REA] = |acc_tgl[11:9];
    evt[mei_pkg::BIT_APP] = |acc_tgl[14:12];
    evt[mei_pkg::BIT_LINE] = line_accum_mode_i & line_accum_end_i;
    evt[mei_pkg::BIT_ACT_A +: 3] = edge_pulse[5:3];
    evt[mei_pkg::BIT_REA_A +: 3] = edge_pulse[8:6];
    evt[mei_pkg::BIT_PSUM1] = edge_pulse[9];
    evt[mei_pkg::BIT_PSUM2] = edge_pulse[10];
    evt[mei_pkg::BIT_PSUM3] = edge_pulse[11];
    // Disable bits gate only the pin, never the event
    evt[mei_pkg::BIT_FREQ_OUT1 +: 3] = edge_pulse[14:12];
    evt[mei_pkg::BIT_DSP_DONE] = dsp_done;
  end

  // Set wins over a same-cycle write-one clear
  always_comb begin
    next_status = status;
    if (wr_go && sel_st) begin
      next_status = status & ~wdat[18:0];
    end
    next_status = next_status | evt;
  end

  assign pending = |(status & event_irq_enable_0);
  assign next_dsp_cnt = (dsp_cnt == 32'(mei_pkg::DSP_DIV - 1)) ? 32'h0 : dsp_cnt + 32'h1;

  always_comb begin
    rd_mux = 32'h0;
    case (1'b1)
      sel_en: rd_mux = {13'h0, event_irq_enable_0};
      sel_st: rd_mux = {13'h0, status};
      sel_mm: rd_mux = {30'h0, measurement_mode_reg};
      sel_cf: rd_mux = {20'h0, freq_out_mode_reg};
      sel_lc: rd_mux = {16'h0, half_cycle_count_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dsp_cnt <= 32'h0;
      dsp_done <= 1'b0;
      acc_prev <= 15'h0;
    end else begin
      dsp_cnt <= next_dsp_cnt;
      dsp_done <= (dsp_cnt == 32'(mei_pkg::DSP_DIV - 1));
      acc_prev <= acc_now;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      acc_done <= 1'b0;
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
    end else begin
      acc_done <= req;
      if (req) begin
        avs_readdata <= avs_read ? rd_mux : 32'h0;
        avs_response <= hit ? 2'h0 : 2'h3;
      end
    end
  end

  // Waitrequest high except on the answer cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~req;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      event_irq_enable_0 <= mei_pkg::ENABLE_RST;
      measurement_mode_reg <= mei_pkg::MEAS_MODE_RST;
      freq_out_mode_reg <= mei_pkg::FREQ_MODE_RST;
      half_cycle_count_reg <= mei_pkg::HALF_CYC_RST;
      status <= 19'h0;
      irq_n_o <= 1'b1;
      freq_out_o <= 3'h7;
    end else begin
      if (wr_go && sel_en) begin
        event_irq_enable_0 <= (event_irq_enable_0 & ~be_mask[18:0]) | wdat[18:0];
      end
      if (wr_go && sel_mm) begin
        measurement_mode_reg <= wdat[1:0];
      end
      if (wr_go && sel_cf) begin
        freq_out_mode_reg <= (freq_out_mode_reg & ~be_mask[11:0]) | wdat[11:0];
      end
      if (wr_go && sel_lc) begin
        half_cycle_count_reg <= (half_cycle_count_reg & ~be_mask[15:0]) | wdat[15:0];
      end
      status <= next_status;
      irq_n_o <= ~pending;
      // Disabled pin rests high; its interrupt still fires
      freq_out_o <= cf_run | freq_out_mode_reg[mei_pkg::CFM_DIS1 +: 3];
    end
  end
endmodule // mei_irq

/* logic/mei_pkg.sv */
// Package for the metering event interrupt mask block.
// Assumes a single 40 MHz clock and an Avalon-MM register slave.
package mei_pkg;
  // Register word offsets (byte address = index * 4)
  localparam logic [15:0] OFS_ENABLE_0 = 16'he50a;
  localparam logic [15:0] OFS_STATUS_0 = 16'he510;
  localparam logic [15:0] OFS_MEAS_MODE = 16'he511;
  localparam logic [15:0] OFS_FREQ_MODE = 16'he512;
  localparam logic [15:0] OFS_HALF_CYC = 16'he513;
  // Event bit positions
  localparam int BIT_TOT_ACT = 0;
  localparam int BIT_FUND_ACT = 1;
  localparam int BIT_TOT_REA = 2;
  localparam int BIT_FUND_REA = 3;
  localparam int BIT_APP = 4;
  localparam int BIT_LINE = 5;
  localparam int BIT_ACT_A = 6;
  localparam int BIT_PSUM1 = 9;
  localparam int BIT_REA_A = 10;
  localparam int BIT_PSUM2 = 13;
  localparam int BIT_FREQ_OUT1 = 14;
  localparam int BIT_DSP_DONE = 17;
  localparam int BIT_PSUM3 = 18;
  localparam int NUM_EVT = 19;
  localparam int ACC_HALF_BIT = 30;
  // Mode register field positions
  localparam int MM_ACT_SEL = 0;
  localparam int MM_REA_SEL = 1;
  localparam int CFM_SEL1_LO = 0;
  localparam int CFM_DIS1 = 9;
  // Reset values
  localparam logic [18:0] ENABLE_RST = 19'h00000;
  localparam logic [11:0] FREQ_MODE_RST = 12'h000;
  localparam logic [1:0] MEAS_MODE_RST = 2'h0;
  localparam logic [15:0] HALF_CYC_RST = 16'h0000;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int DSP_RATE_HZ = 8000;
  localparam int DSP_DIV = CLK_HZ / DSP_RATE_HZ;
endpackage

/* logic/mei_edge.sv */
// Per-source edge/sign-change detector bank.
// Assumes sources synchronous to ref_clk_i; one-cycle pulses out.
`timescale 1ns/10ps
module mei_edge (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [14:0] lvl_i,
  input wire logic [14:0] fall_only_i,
  output logic [14:0] pulse_o
);
  logic [14:0] prev;
  logic [14:0] seen;
  genvar g;
  generate
    for (g = 0; g < 15; g++) begin : g_det
      // First sample after reset only primes history
      assign pulse_o[g] = seen[g] & (fall_only_i[g] ? (prev[g] & ~lvl_i[g])
                                                    : (prev[g] ^ lvl_i[g]));
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          prev[g] <= 1'b0;
          seen[g] <= 1'b0;
        end else begin
          prev[g] <= lvl_i[g];
          seen[g] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule // mei_edge

/* sim/mei_irq_props.sv */
// Port checker for the event interrupt mask block.
// Assumes the one-cycle Avalon-MM answer of the design.
`timescale 1ns/10ps
module mei_irq_props (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [2:0] freq_out_pulse_i,
  input wire logic [2:0] freq_out_o,
  input wire logic irq_n_o
);
  wire logic mapped;
  wire logic en_off;
  assign mapped = avs_address == mei_pkg::OFS_ENABLE_0[13:0] ||
    (avs_address >= mei_pkg::OFS_STATUS_0[13:0] && avs_address <= mei_pkg::OFS_HALF_CYC[13:0]);
  assign en_off = avs_write && !avs_waitrequest && avs_address == mei_pkg::OFS_ENABLE_0[13:0] &&
    avs_byteenable == 4'hf && avs_writedata[18:0] == 19'h0;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  idle_wait_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  answer_time_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  reserved_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:19] == 13'h0)
    else $error("reserved bits read nonzero");
  unmapped_resp_a: assert property (avs_read && !avs_waitrequest && !mapped |->
    avs_response == 2'h3 && avs_readdata == 32'h0) else $error("unmapped read answered");
  mapped_resp_a: assert property (!avs_waitrequest && mapped |-> avs_response == 2'h0)
    else $error("mapped access refused");
  freq_delay_a: assert property ((~freq_out_o & $past(freq_out_pulse_i)) == 3'h0)
    else $error("freq output low without input pulse");
  irq_mask_off_a: assert property (en_off |=> ##1 irq_n_o)
    else $error("irq held with all enables off");
  cover property ($fell(irq_n_o));
  cover property (avs_read && !avs_waitrequest && !mapped);
  cover property (!irq_n_o ##2 irq_n_o);
endmodule // mei_irq_props

bind mei_irq mei_irq_props u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .freq_out_pulse_i(freq_out_pulse_i),
  .freq_out_o(freq_out_o), .irq_n_o(irq_n_o));

/* sim/test_metering_event_irq_mask.sv */
// Self-checking bench for the event interrupt mask block.
// Assumes the design's Avalon-MM slave and registered event path.
`timescale 1ns/10ps
module test_metering_event_irq_mask;
  localparam logic [15:0] EN = mei_pkg::OFS_ENABLE_0;
  localparam logic [15:0] ST = mei_pkg::OFS_STATUS_0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] addr = 14'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata, d;
  logic [1:0] resp, r;
  logic wait_req, irq_n, lm = 1'b1, le = 1'b0;
  logic [2:0] ta = 3'h0, fa = 3'h0, tr = 3'h0, fr = 3'h0, ap = 3'h0, fo;
  logic [2:0] tan = 3'h0, fan = 3'h0, trn = 3'h0, frn = 3'h0, fp = 3'h7;
  logic [7:0] pn = 8'h0;
  int fail_count = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  mei_irq dut (.ref_clk_i(clk), .rst_n_i(rst_n), .avs_address(addr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .avs_response(resp), .tot_act_hi_i(ta), .fund_act_hi_i(fa),
    .tot_rea_hi_i(tr), .fund_rea_hi_i(fr), .app_hi_i(ap), .line_accum_mode_i(lm),
    .line_accum_end_i(le), .tot_act_neg_i(tan), .fund_act_neg_i(fan), .tot_rea_neg_i(trn),
    .fund_rea_neg_i(frn), .power_neg_i(pn), .freq_out_pulse_i(fp), .freq_out_o(fo),
    .irq_n_o(irq_n));
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] v);
    addr <= a[13:0];
    wdata <= v;
    wr_en <= w;
    rd_en <= ~w;
    @(posedge clk);
    while (wait_req) @(posedge clk);
    d = rdata;
    r = resp;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One event source per enable bit except 17; sign sums use power codes 1..3
  task automatic fire(input int b);
    case (b)
      0: ta[0] <= ~ta[0];
      1: fa[1] <= ~fa[1];
      2: tr[2] <= ~tr[2];
      3: fr[0] <= ~fr[0];
      4: ap[1] <= ~ap[1];
      5: le <= 1'b1;
      6, 7, 8: tan[b-6] <= ~tan[b-6];
      9: pn[1] <= ~pn[1];
      13: pn[2] <= ~pn[2];
      18: pn[3] <= ~pn[3];
      14, 15, 16: fp[b-14] <= 1'b0;
      default: trn[b-10] <= ~trn[b-10];
    endcase
    @(posedge clk);
    le <= 1'b0;
    fp <= 3'h7;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({irq_n, fo}, 32'hf);
    xfer(0, EN, 0);
    chk(d, 0);
    xfer(1, EN, 32'hffffffff);
    be <= 4'h0;
    xfer(1, EN, 0);
    be <= 4'hf;
    xfer(0, EN, 0);
    chk(d, 32'h7ffff);
    xfer(0, 16'h0, 0);
    chk(r, 32'h3);
    // Select codes 1,2,3 and all three pins disabled
    xfer(1, mei_pkg::OFS_FREQ_MODE, 32'hed1);
    for (int b = 0; b < 19; b++) begin
      if (b == 17) continue;
      xfer(1, ST, 32'h7ffff);
      xfer(1, EN, 0);
      fire(b);
      repeat (3) @(posedge clk);
      chk(irq_n, 1);
      xfer(0, ST, 0);
      chk(d[b], 1);
      xfer(1, EN, 1 << b);
      @(posedge clk);
      chk(irq_n, 0);
      xfer(1, ST, 1 << b);
      @(posedge clk);
      chk(irq_n, 1);
    end
    chk(fo, 32'h7);
    // Pins enabled again: a pulse must reach the output one cycle later
    xfer(1, mei_pkg::OFS_FREQ_MODE, 32'h0d1);
    fp <= 3'h6;
    @(posedge clk);
    fp <= 3'h7;
    @(posedge clk);
    chk(fo, 32'h6);
    xfer(1, mei_pkg::OFS_MEAS_MODE, 32'h3);
    xfer(1, ST, 32'h7ffff);
    fan[0] <= ~fan[0];
    frn[1] <= ~frn[1];
    repeat (4) @(posedge clk);
    xfer(0, ST, 0);
    chk(d & 32'h840, 32'h840);
    xfer(1, EN, 32'h20000);
    for (int i = 0; i < 6000 && irq_n; i++) @(posedge clk);
    chk(irq_n, 0);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule // test_metering_event_irq_mask
